// [design/see_pkg.sv]
// Shared constants, state codes and the bus event carrier for the serial EEPROM slave.
package see_pkg;

   localparam int CLK_PERIOD_NS = 8;
   localparam int NS_PER_MS     = 1_000_000;

   localparam int GLITCH_NS  = 100;
   localparam int GLITCH_CYC = (GLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   localparam int INTERNAL_WRITE_DURATION_MS  = 5;
   localparam int INTERNAL_WRITE_DURATION_CYC =
      INTERNAL_WRITE_DURATION_MS * NS_PER_MS / CLK_PERIOD_NS;

   localparam int POWER_UP_READY_DELAY_MS  = 1;
   localparam int POWER_UP_READY_DELAY_CYC =
      POWER_UP_READY_DELAY_MS * NS_PER_MS / CLK_PERIOD_NS;

   localparam int ADDR_W    = 8;
   localparam int PAGE_W    = 4;
   localparam int MEM_DEPTH = 256;
   localparam int PAGE_SIZE = 16;

   localparam logic [3:0] DEV_TYPE  = 4'hA;
   localparam logic [3:0] BITS_BYTE = 4'h8;
   localparam int         MSB_POS   = 7;
   localparam int         NXT_POS   = 6;
   localparam int         RW_POS    = 0;

   typedef enum logic [3:0] {
      ST_IDLE    = 4'h0,
      ST_DEVADR  = 4'h1,
      ST_DEVACK  = 4'h3,
      ST_WADR    = 4'h2,
      ST_WADRACK = 4'h6,
      ST_WDAT    = 4'h7,
      ST_WDATACK = 4'h5,
      ST_RDAT    = 4'h4,
      ST_RDACK   = 4'hC
   } see_state_t;

   typedef struct packed {
      logic sda;
      logic scl_rise;
      logic scl_fall;
      logic start;
      logic stop;
   } see_bus_ev_t;

endpackage

// [design/see_filt.sv]
// Two-flop synchroniser followed by a stability filter for one bus line.
`timescale 1ns/10ps
module see_filt #(
   parameter int CYC = see_pkg::GLITCH_CYC
) (
   // Clock and reset.
   input  wire logic clock,
   input  wire logic rstn,
   // Raw pin and filtered level.
   input  wire logic raw,
   output logic      level
);
   localparam int CW = $clog2(CYC + 1);

   logic          sync1_ff;
   logic          sync2_ff;
   logic          level_ff;
   logic [CW-1:0] cnt_ff;

   // A change is accepted only after it has held for more than CYC samples.
   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         sync1_ff <= 1'b1;
         sync2_ff <= 1'b1;
         level_ff <= 1'b1;
         cnt_ff   <= '0;
      end
      else
      begin
         sync1_ff <= raw;
         sync2_ff <= sync1_ff;
         if (sync2_ff == level_ff)
            cnt_ff <= '0;
         else if (cnt_ff == CW'(CYC))
         begin
            level_ff <= sync2_ff;
            cnt_ff   <= '0;
         end
         else
            cnt_ff <= cnt_ff + 1'b1;
      end
   end

   assign level = level_ff;
endmodule

// [design/see_timer.sv]
// Down counter that reports busy for a fixed number of cycles after a launch.
`timescale 1ns/10ps
module see_timer #(
   parameter int CYCLES        = 16,
   parameter bit BUSY_AT_RESET = 1'b0
) (
   // Clock and reset.
   input  wire logic clock,
   input  wire logic rstn,
   // Control and status.
   input  wire logic launch,
   output logic      busy
);
   localparam int CW = $clog2(CYCLES + 1);

   logic [CW-1:0] cnt_ff;

   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
         cnt_ff <= BUSY_AT_RESET ? CW'(CYCLES) : '0;
      else if (launch)
         cnt_ff <= CW'(CYCLES);
      else if (cnt_ff != '0)
         cnt_ff <= cnt_ff - 1'b1;
   end

   assign busy = (cnt_ff != '0);
endmodule

// [design/see_top.sv]
// Bus-facing slave logic of a small serial EEPROM with page buffer and write timing.
`timescale 1ns/10ps
module see_top #(
   parameter int WRITE_CYC = see_pkg::INTERNAL_WRITE_DURATION_CYC,
   parameter int READY_CYC = see_pkg::POWER_UP_READY_DELAY_CYC
) (
   // Clock and power-on reset.
   input  wire logic clock,
   input  wire logic rstn,
   // Serial bus.
   input  wire logic scl_i,
   input  wire logic sda_i,
   output logic      sda_o,
   output logic      sda_oe,
   // Strap and protect pins.
   input  wire logic strap_select_bit0,
   input  wire logic strap_select_bit1,
   input  wire logic strap_select_bit2,
   input  wire logic wp_i,
   // Status.
   output logic      write_busy,
   output logic      ready
);
   localparam int NPIN = 4;

   see_pkg::see_bus_ev_t ev;
   see_pkg::see_state_t  state_ff;
   see_pkg::see_state_t  nxt_state;

   logic                         scl_f;
   logic                         sda_f;
   logic                         scl_q_ff;
   logic                         sda_q_ff;
   logic [NPIN-1:0]              pin_raw;
   logic [NPIN-1:0]              pin_s1_ff;
   logic [NPIN-1:0]              pin_s2_ff;
   logic [2:0]                   strap;
   logic                         wp_s;
   logic [3:0]                   cnt_ff;
   logic [3:0]                   nxt_cnt;
   logic [7:0]                   sh_ff;
   logic [7:0]                   nxt_sh;
   logic [7:0]                   tx_ff;
   logic [7:0]                   nxt_tx;
   logic                         oe_ff;
   logic                         nxt_oe;
   logic [see_pkg::ADDR_W-1:0]   addr_ff;
   logic [see_pkg::ADDR_W-1:0]   nxt_addr;
   logic                         rd_ff;
   logic                         nxt_rd;
   logic                         wp_lat_ff;
   logic                         nxt_wp_lat;
   logic                         mack_ff;
   logic                         nxt_mack;
   logic [see_pkg::PAGE_SIZE-1:0] valid_ff;
   logic [see_pkg::PAGE_SIZE-1:0] nxt_valid;
   logic                         buf_we;
   logic                         commit;
   logic                         pu_busy;
   logic                         wr_busy;
   logic                         byte_done;
   logic                         rx_state;
   logic                         cnt_state;
   logic                         dev_match;
   logic [7:0]                   mem_rd;
   logic [see_pkg::PAGE_W-1:0]   lo_inc;

   logic [7:0] mem  [see_pkg::MEM_DEPTH];
   logic [7:0] pbuf [see_pkg::PAGE_SIZE];

   // Bus lines pass the synchroniser and the glitch filter first.
   see_filt #(
      .CYC (see_pkg::GLITCH_CYC)
   ) u_filt_scl (
      .clock (clock),
      .rstn  (rstn),
      .raw   (scl_i),
      .level (scl_f)
   );

   see_filt #(
      .CYC (see_pkg::GLITCH_CYC)
   ) u_filt_sda (
      .clock (clock),
      .rstn  (rstn),
      .raw   (sda_i),
      .level (sda_f)
   );

   // Internal write cycle timer, launched by STOP after accepted data.
   see_timer #(
      .CYCLES        (WRITE_CYC),
      .BUSY_AT_RESET (1'b0)
   ) u_wr_timer (
      .clock  (clock),
      .rstn   (rstn),
      .launch (commit),
      .busy   (wr_busy)
   );

   // Power-up delay counts from reset release before commands are taken.
   see_timer #(
      .CYCLES        (READY_CYC),
      .BUSY_AT_RESET (1'b1)
   ) u_pu_timer (
      .clock  (clock),
      .rstn   (rstn),
      .launch (1'b0),
      .busy   (pu_busy)
   );

   // Static pins are synchronised by two flops each.
   assign pin_raw = {wp_i, strap_select_bit2, strap_select_bit1, strap_select_bit0};

   genvar gi;
   generate
      for (gi = 0; gi < NPIN; gi++)
      begin : g_pin_sync
         always_ff @(posedge clock or negedge rstn)
         begin
            if (!rstn)
            begin
               pin_s1_ff[gi] <= 1'b0;
               pin_s2_ff[gi] <= 1'b0;
            end
            else
            begin
               pin_s1_ff[gi] <= pin_raw[gi];
               pin_s2_ff[gi] <= pin_s1_ff[gi];
            end
         end
      end
   endgenerate

   assign strap = pin_s2_ff[2:0];
   assign wp_s  = pin_s2_ff[3];

   // Edge and condition detection on the filtered lines.
   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         scl_q_ff <= 1'b1;
         sda_q_ff <= 1'b1;
      end
      else
      begin
         scl_q_ff <= scl_f;
         sda_q_ff <= sda_f;
      end
   end

   assign ev.sda      = sda_f;
   assign ev.scl_rise = scl_f & ~scl_q_ff;
   assign ev.scl_fall = ~scl_f & scl_q_ff;
   assign ev.start    = scl_f & scl_q_ff & sda_q_ff & ~sda_f;
   assign ev.stop     = scl_f & scl_q_ff & ~sda_q_ff & sda_f;

   // Decoding of the current state and byte.
   assign byte_done = (cnt_ff == see_pkg::BITS_BYTE);
   assign rx_state  = (state_ff == see_pkg::ST_DEVADR) || (state_ff == see_pkg::ST_WADR) ||
                      (state_ff == see_pkg::ST_WDAT);
   assign cnt_state = rx_state || (state_ff == see_pkg::ST_RDAT);
   assign dev_match = (sh_ff[7:4] == see_pkg::DEV_TYPE) &&
                      (sh_ff[3:1] == strap) &&
                      !wr_busy && !pu_busy;
   assign mem_rd    = mem[addr_ff];
   assign lo_inc    = addr_ff[see_pkg::PAGE_W-1:0] + 1'b1;

   always_comb
   begin
      nxt_state  = state_ff;
      nxt_cnt    = cnt_ff;
      nxt_sh     = sh_ff;
      nxt_tx     = tx_ff;
      nxt_oe     = oe_ff;
      nxt_addr   = addr_ff;
      nxt_rd     = rd_ff;
      nxt_wp_lat = wp_lat_ff;
      nxt_mack   = mack_ff;
      nxt_valid  = valid_ff;
      buf_we     = 1'b0;
      commit     = 1'b0;
      if (ev.stop)
      begin
         // Accepted data becomes an internal write; a read just ends.
         nxt_state = see_pkg::ST_IDLE;
         nxt_oe    = 1'b0;
         commit    = |valid_ff;
         nxt_valid = '0;
      end
      else if (ev.start)
      begin
         // A repeated START drops pending data; the counter keeps its load.
         nxt_state = see_pkg::ST_DEVADR;
         nxt_cnt   = '0;
         nxt_oe    = 1'b0;
         nxt_valid = '0;
      end
      else
      begin
         if (ev.scl_rise && cnt_state)
            nxt_cnt = cnt_ff + 1'b1;
         if (ev.scl_rise && rx_state)
            nxt_sh = {sh_ff[6:0], ev.sda};
         unique case (state_ff)
            see_pkg::ST_IDLE:
            begin
               nxt_oe = 1'b0;
            end
            see_pkg::ST_DEVADR:
            begin
               if (ev.scl_fall && byte_done)
               begin
                  nxt_cnt = '0;
                  nxt_rd  = sh_ff[see_pkg::RW_POS];
                  if (dev_match)
                  begin
                     nxt_oe    = 1'b1;
                     nxt_state = see_pkg::ST_DEVACK;
                  end
                  else
                     nxt_state = see_pkg::ST_IDLE;
               end
            end
            see_pkg::ST_DEVACK:
            begin
               if (ev.scl_fall)
               begin
                  nxt_cnt = '0;
                  if (rd_ff)
                  begin
                     // Read starts at the counter, which then moves on.
                     nxt_tx    = mem_rd;
                     nxt_oe    = ~mem_rd[see_pkg::MSB_POS];
                     nxt_addr  = addr_ff + 1'b1;
                     nxt_state = see_pkg::ST_RDAT;
                  end
                  else
                  begin
                     nxt_oe    = 1'b0;
                     nxt_state = see_pkg::ST_WADR;
                  end
               end
            end
            see_pkg::ST_WADR:
            begin
               if (ev.scl_fall && byte_done)
               begin
                  nxt_cnt   = '0;
                  nxt_addr  = sh_ff;
                  nxt_oe    = 1'b1;
                  nxt_state = see_pkg::ST_WADRACK;
               end
            end
            see_pkg::ST_WADRACK:
            begin
               if (ev.scl_fall)
               begin
                  nxt_oe     = 1'b0;
                  nxt_wp_lat = wp_s;
                  nxt_state  = see_pkg::ST_WDAT;
               end
            end
            see_pkg::ST_WDAT:
            begin
               if (ev.scl_fall && byte_done)
               begin
                  nxt_cnt = '0;
                  if (wp_lat_ff)
                  begin
                     // Protected: no acknowledge and the whole write is dropped.
                     nxt_valid = '0;
                     nxt_state = see_pkg::ST_IDLE;
                  end
                  else
                  begin
                     buf_we = 1'b1;
                     nxt_valid[addr_ff[see_pkg::PAGE_W-1:0]] = 1'b1;
                     nxt_addr  = {addr_ff[see_pkg::ADDR_W-1:see_pkg::PAGE_W], lo_inc};
                     nxt_oe    = 1'b1;
                     nxt_state = see_pkg::ST_WDATACK;
                  end
               end
            end
            see_pkg::ST_WDATACK:
            begin
               if (ev.scl_fall)
               begin
                  nxt_oe    = 1'b0;
                  nxt_state = see_pkg::ST_WDAT;
               end
            end
            see_pkg::ST_RDAT:
            begin
               if (ev.scl_fall)
               begin
                  if (byte_done)
                  begin
                     nxt_oe    = 1'b0;
                     nxt_state = see_pkg::ST_RDACK;
                  end
                  else
                  begin
                     nxt_tx = {tx_ff[6:0], 1'b0};
                     nxt_oe = ~tx_ff[see_pkg::NXT_POS];
                  end
               end
            end
            see_pkg::ST_RDACK:
            begin
               if (ev.scl_rise)
                  nxt_mack = ~ev.sda;
               if (ev.scl_fall)
               begin
                  nxt_cnt = '0;
                  if (mack_ff)
                  begin
                     // Acknowledged: next byte, the counter wraps at the top.
                     nxt_tx    = mem_rd;
                     nxt_oe    = ~mem_rd[see_pkg::MSB_POS];
                     nxt_addr  = addr_ff + 1'b1;
                     nxt_state = see_pkg::ST_RDAT;
                  end
                  else
                     nxt_state = see_pkg::ST_IDLE;
               end
            end
            default:
            begin
               nxt_oe    = 1'b0;
               nxt_state = see_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // Control state; the power-on reset puts the slave in standby.
   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         state_ff  <= see_pkg::ST_IDLE;
         cnt_ff    <= '0;
         sh_ff     <= '0;
         tx_ff     <= '0;
         oe_ff     <= 1'b0;
         addr_ff   <= '0;
         rd_ff     <= 1'b0;
         wp_lat_ff <= 1'b0;
         mack_ff   <= 1'b0;
         valid_ff  <= '0;
      end
      else
      begin
         state_ff  <= nxt_state;
         cnt_ff    <= nxt_cnt;
         sh_ff     <= nxt_sh;
         tx_ff     <= nxt_tx;
         oe_ff     <= nxt_oe;
         addr_ff   <= nxt_addr;
         rd_ff     <= nxt_rd;
         wp_lat_ff <= nxt_wp_lat;
         mack_ff   <= nxt_mack;
         valid_ff  <= nxt_valid;
      end
   end

   // Page buffer fill, and commit of the loaded bytes into their page at STOP.
   always_ff @(posedge clock)
   begin
      if (buf_we)
         pbuf[addr_ff[see_pkg::PAGE_W-1:0]] <= sh_ff;
      for (int i = 0; i < see_pkg::PAGE_SIZE; i++)
      begin
         if (commit && valid_ff[i])
            mem[{addr_ff[see_pkg::ADDR_W-1:see_pkg::PAGE_W], see_pkg::PAGE_W'(i)}] <= pbuf[i];
      end
   end

   // Open-drain output: the pin is only ever pulled low.
   assign sda_o      = 1'b0;
   assign sda_oe     = oe_ff;
   assign write_busy = wr_busy;
   assign ready      = ~pu_busy;
endmodule

// [dv/see_assertions.sv]
// Pin-level concurrent checks for the serial EEPROM slave.
`timescale 1ns/10ps
module see_assertions #(
   parameter int WRITE_CYC = 200,
   parameter int READY_CYC = 50
) (
   // Clock and reset.
   input wire logic clock,
   input wire logic rstn,
   // Serial bus.
   input wire logic scl_i,
   input wire logic sda_i,
   input wire logic sda_o,
   input wire logic sda_oe,
   // Strap and protect pins.
   input wire logic strap_select_bit0,
   input wire logic strap_select_bit1,
   input wire logic strap_select_bit2,
   input wire logic wp_i,
   // Status.
   input wire logic write_busy,
   input wire logic ready
);
   int   rcnt_ff;
   int   bcnt_ff;
   int   sf_ff;
   logic scl_q_ff;
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rstn);
   // Counts cycles since reset, busy cycles and cycles since the last SCL fall.
   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         rcnt_ff  <= 0;
         bcnt_ff  <= 0;
         sf_ff    <= 300;
         scl_q_ff <= 1'b1;
      end
      else
      begin
         rcnt_ff  <= (rcnt_ff > READY_CYC + 4) ? rcnt_ff : rcnt_ff + 1;
         bcnt_ff  <= write_busy ? bcnt_ff + 1 : 0;
         sf_ff    <= (scl_q_ff && !scl_i) ? 0 : ((sf_ff > 299) ? sf_ff : sf_ff + 1);
         scl_q_ff <= scl_i;
      end
   end
   sequence s_scl_rise;
      $rose(scl_i);
   endsequence
   sequence s_oe_hold;
      $stable(sda_oe) [*8];
   endsequence
   property p_odrain;
      sda_o == 1'b0;
   endproperty
   a_odrain: assert property (p_odrain) else $error("sda_o driven high");
   property p_ready;
      (rcnt_ff < READY_CYC - 2 |-> !ready) and (rcnt_ff > READY_CYC + 2 |-> ready);
   endproperty
   a_ready: assert property (p_ready) else $error("ready at wrong time");
   property p_busy_len;
      $fell(write_busy) |-> (bcnt_ff >= WRITE_CYC - 1 && bcnt_ff <= WRITE_CYC + 1);
   endproperty
   a_busy_len: assert property (p_busy_len) else $error("busy length wrong");
   property p_busy_quiet;
      write_busy |-> !sda_oe;
   endproperty
   a_busy_quiet: assert property (p_busy_quiet) else $error("ack while busy");
   property p_busy_stop;
      $rose(write_busy) |-> (scl_i && sda_i);
   endproperty
   a_busy_stop: assert property (p_busy_stop) else $error("busy not after stop");
   property p_not_ready;
      !ready |-> !sda_oe;
   endproperty
   a_not_ready: assert property (p_not_ready) else $error("drive before ready");
   property p_stand;
      s_scl_rise |=> s_oe_hold;
   endproperty
   a_stand: assert property (p_stand) else $error("sda moved in high phase");
   property p_oe_timing;
      $changed(sda_oe) |-> (sf_ff >= 10 && sf_ff <= 26);
   endproperty
   a_oe_timing: assert property (p_oe_timing) else $error("sda not after fall");
endmodule
bind see_top see_assertions #(.WRITE_CYC(WRITE_CYC), .READY_CYC(READY_CYC)) i_chk (
   .clock(clock), .rstn(rstn), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o),
   .sda_oe(sda_oe), .strap_select_bit0(strap_select_bit0),
   .strap_select_bit1(strap_select_bit1), .strap_select_bit2(strap_select_bit2),
   .wp_i(wp_i), .write_busy(write_busy), .ready(ready));

// [dv/see_master.sv]
// Behavioural bus master that clocks bytes through the EEPROM slave.
`timescale 1ns/10ps
module see_master #(
   parameter int Q = 30
) (
   // Bench clock paces every bus phase.
   input  wire logic       clock,
   // Bus lines.
   input  wire logic       sda,
   output logic            scl,
   output logic            pull,
   // Result of each byte.
   output logic            res_v,
   output logic [8:0]      res_d
);
   initial
   begin
      scl   = 1'b1;
      pull  = 1'b0;
      res_v = 1'b0;
      res_d = 9'h000;
   end
   task automatic wt(input int n);
      repeat (n) @(negedge clock);
   endtask
   task automatic report(input logic [8:0] v);
      res_d = v;
      res_v = 1'b1;
      wt(1);
      res_v = 1'b0;
   endtask
   // Data moves only in the low phase; a one is sent by releasing the line.
   task automatic bitx(input logic b, output logic s);
      wt(Q);
      pull = !b;
      wt(Q);
      scl = 1'b1;
      wt(Q);
      s = sda;
      wt(Q);
      scl = 1'b0;
   endtask
   task automatic start();
      if (scl === 1'b0)
      begin
         wt(Q);
         pull = 1'b0;
         wt(Q);
         scl = 1'b1;
      end
      wt(2 * Q);
      pull = 1'b1;
      wt(2 * Q);
      scl = 1'b0;
   endtask
   task automatic stop();
      wt(Q);
      pull = 1'b1;
      wt(Q);
      scl = 1'b1;
      wt(2 * Q);
      pull = 1'b0;
      wt(2 * Q);
   endtask
   // Short pulses on both lines while the bus is idle.
   task automatic glitch();
      scl = 1'b0;
      wt(12);
      scl = 1'b1;
      wt(40);
      pull = 1'b1;
      wt(12);
      pull = 1'b0;
      wt(40);
      scl = 1'b0;
   endtask
   task automatic wbyte(input logic [7:0] b);
      logic a;
      for (int i = 7; i >= 0; i--)
         bitx(b[i], a);
      bitx(1'b1, a);
      report({a, b});
   endtask
   task automatic rbyte(input logic nak);
      logic [7:0] d;
      logic       a;
      for (int i = 7; i >= 0; i--)
      begin
         bitx(1'b1, a);
         d[i] = a;
      end
      bitx(nak, a);
      report({1'b0, d});
   endtask
endmodule

// [dv/tb_top.sv]
// Self-checking bench for the serial EEPROM slave with a bus master model.
`timescale 1ns/10ps
module tb_top;
   localparam int WCYC     = 3000;
   localparam int RCYC     = 50;
   localparam int LIMIT_NS = 760_000;
   logic        clock       = 1'b0;
   logic        rstn        = 1'b0;
   logic [2:0]  strap       = 3'h0;
   logic        wp          = 1'b0;
   logic [31:0] lfsr_st     = 32'h0000_577e;
   int          errors      = 0;
   int          comparisons = 0;
   logic        sda_oe;
   logic        sda_o;
   logic        write_busy;
   logic        ready;
   logic        scl;
   logic        pull;
   logic        res_v;
   logic [8:0]  res_d;
   logic [8:0]  expq[$];
   logic [7:0]  mem_exp[256];
   logic [7:0]  ptr;
   wire         sda;
   always #4 clock = ~clock;
   assign sda = !(sda_oe || pull);
   see_top #(.WRITE_CYC(WCYC), .READY_CYC(RCYC)) i_dut (
      .clock(clock), .rstn(rstn), .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe),
      .strap_select_bit0(strap[0]), .strap_select_bit1(strap[1]),
      .strap_select_bit2(strap[2]), .wp_i(wp), .write_busy(write_busy), .ready(ready));
   see_master i_mst (
      .clock(clock), .sda(sda), .scl(scl), .pull(pull), .res_v(res_v), .res_d(res_d));
   task automatic complete_run();
      $display("errors=%0d comparisons=%0d", errors, comparisons);
      if (errors == 0 && comparisons > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic cmp(input logic [8:0] got, input logic [8:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic logic [7:0] dadr(input logic r);
      return {4'hA, strap, r};
   endfunction
   task automatic wb(input logic [7:0] b, input logic nak);
      expq.push_back({nak, b});
      i_mst.wbyte(b);
   endtask
   task automatic rb(input logic nak);
      expq.push_back({1'b0, mem_exp[ptr]});
      i_mst.rbyte(nak);
      ptr++;
   endtask
   task automatic wait_idle();
      int t = 0;
      while (write_busy !== 1'b0 && t < WCYC + 20)
      begin
         @(negedge clock);
         t++;
      end
      cmp({8'h00, write_busy}, 9'h000);
   endtask
   task automatic wr(input logic [7:0] ba, input int n, input logic prot, input logic poll);
      logic [3:0] lo;
      i_mst.start();
      wb(dadr(1'b0), 1'b0);
      wb(ba, 1'b0);
      for (int k = 0; k < n; k++)
      begin
         lfsr_st = lfsr(lfsr_st);
         lo = ba[3:0] + k[3:0];
         wb(lfsr_st[7:0], prot);
         if (!prot)
            mem_exp[{ba[7:4], lo}] = lfsr_st[7:0];
      end
      i_mst.stop();
      cmp({8'h00, write_busy}, {8'h00, !prot});
      if (poll)
      begin
         i_mst.start();
         wb(dadr(1'b0), 1'b1);
         i_mst.stop();
         wait_idle();
         i_mst.start();
         wb(dadr(1'b0), 1'b0);
         i_mst.stop();
      end
   endtask
   task automatic rd(input logic [7:0] ba, input logic sel, input int n);
      if (sel)
      begin
         i_mst.start();
         wb(dadr(1'b0), 1'b0);
         wb(ba, 1'b0);
         ptr = ba;
      end
      i_mst.start();
      wb(dadr(1'b1), 1'b0);
      for (int k = 0; k < n; k++)
         rb(k == n - 1);
      i_mst.stop();
      cmp({8'h00, write_busy}, 9'h000);
   endtask
   // Takes the oldest expected byte whenever the master reports a result.
   always @(posedge clock)
   begin
      if (res_v === 1'b1)
         cmp(res_d, expq.pop_front());
   end
   initial
   begin
      #(LIMIT_NS);
      errors++;
      complete_run();
   end
   initial
   begin
      logic [3:0] f;
      lfsr_st = lfsr(lfsr_st);
      strap = lfsr_st[2:0];
      repeat (5) @(negedge clock);
      rstn = 1'b1;
      cmp({8'h00, ready}, 9'h000);
      repeat (RCYC + 4) @(negedge clock);
      cmp({8'h00, ready}, 9'h001);
      i_mst.glitch();
      wb(dadr(1'b0), 1'b1);
      for (int i = 0; i < 5; i++)
      begin
         f = (4'h1 << i) >> 1;
         i_mst.start();
         wb((i == 4) ? {4'h5, strap, 1'b0} : {4'hA, strap ^ f[2:0], 1'b0}, i != 0);
         if (i != 0)
            wb(dadr(1'b0), 1'b1);
         i_mst.stop();
      end
      wr(8'hFF, 1, 1'b0, 1'b1);
      wr(8'h0F, 17, 1'b0, 1'b1);
      rd(8'hFF, 1'b1, 2);
      rd(8'h00, 1'b0, 3);
      wp = 1'b1;
      wr(8'h05, 1, 1'b1, 1'b0);
      wp = 1'b0;
      rd(8'h05, 1'b1, 1);
      wr(8'h20, 1, 1'b0, 1'b0);
      rstn = 1'b0;
      @(negedge clock);
      cmp({7'h00, write_busy, ready}, 9'h000);
      rstn = 1'b1;
      repeat (RCYC + 4) @(negedge clock);
      rd(8'h20, 1'b1, 1);
      complete_run();
   end
endmodule
